// [egress_scheduler.v]
/*
 * two-queue egress arbiter: strict priority or weighted high/low
 * ratio. assumes grant is taken when a frame starts.
 */
`timescale 1ns/10ps
`default_nettype none
`include "switch_policy_defines.vh"
module egress_scheduler (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire [1:0] scheme_i,
    input wire high_pend_i,
    input wire low_pend_i,
    input wire frame_start_i,
    output wire pick_high_o
);
    reg [3:0] high_cnt_reg;
    reg [3:0] high_cnt_next;
    reg [3:0] ratio;

    // ratio from scheme code
    always @* begin
        case (scheme_i)
            2'b01: ratio = `RATIO_10;
            2'b10: ratio = `RATIO_5;
            2'b11: ratio = `RATIO_2;
            default: ratio = 4'h0;
        endcase
    end

    // strict mode always favours high, else low after ratio highs
    assign pick_high_o = high_pend_i && (scheme_i == 2'b00 || !low_pend_i || high_cnt_reg < ratio);

    always @* begin
        high_cnt_next = high_cnt_reg;
        if (frame_start_i) begin
            if (pick_high_o)
                high_cnt_next = (high_cnt_reg < ratio) ? high_cnt_reg + 4'h1 : high_cnt_reg;
            else if (low_pend_i)
                high_cnt_next = 4'h0;
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_b_i)
            high_cnt_reg <= 4'h0;
        else
            high_cnt_reg <= high_cnt_next;
    end
endmodule // egress_scheduler
`default_nettype wire

// [storm_meter.v]
/*
 * per-port broadcast storm budget: counts 64-byte blocks of
 * broadcast data in each period and flags an exhausted budget.
 * assumes period_tick_i pulses once at each period boundary.
 */
`timescale 1ns/10ps
`default_nettype none
module storm_meter (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire enable_i,
    input wire period_tick_i,
    input wire block_i,
    input wire [10:0] budget_i,
    output wire over_o
);
    reg [11:0] used_reg;
    reg [11:0] used_next;

    // count blocks, clear at each period boundary
    always @* begin
        used_next = used_reg;
        if (period_tick_i)
            used_next = 12'h000;
        else if (enable_i && block_i && used_reg < {1'b0, budget_i})
            used_next = used_reg + 12'h001;
    end

    always @(posedge sys_clk_i) begin
        if (!rst_b_i)
            used_reg <= 12'h000;
        else
            used_reg <= used_next;
    end

    // only an enabled port ever discards
    assign over_o = enable_i && (used_reg >= {1'b0, budget_i});
endmodule // storm_meter
`default_nettype wire

// [switch_global_policy_control.v]
/*
 * global policy register bank of a five-port switch with the
 * decisions the bank steers: frame length limit, priority reserve,
 * forwarding options, switch mii mode and broadcast storm budget.
 * assumes register access arrives already decoded from the serial
 * management port as a write strobe and a combinational read, and
 * that strap pins are stable at the first clock after reset is released.
 */
`timescale 1ns/10ps
`default_nettype none
`include "switch_policy_defines.vh"
// How it works
// - size check bit picks 1536 or 1518/1522
// - drop frames above limit; cpu-tagged frames not bound for port 5 get the untagged limit
// - reserve 48 high-priority buffers when set
// - snooping sends igmp frames to mii
// - direct mode takes destination from preamble
// - pre-tag puts source port in preamble
// - scheme selects strict or weighted ratio
// - tag mask uses low 5 vid bits
// - sniff select chooses and or or match
// - back pressure only when enabled
// - half duplex bit selects duplex
// - flow control only when enabled
// - speed bit selects 10 or 100
// - null vid replaced by port vid
// - eleven-bit storm rate split across registers
// - storm period 50ms or 500ms
// - storm rate resets to 0x04A
// - strap pins load four bits on the first clock after reset release
// - huge bit allows 1916 byte frames
// - storm applies only on enabled ports
module switch_global_policy_control (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire size_limit_strap_pin_i,
    input wire duplex_strap_pin_i,
    input wire flow_ctrl_strap_pin_i,
    input wire speed_strap_pin_i,
    input wire [7:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    input wire frame_end_i,
    input wire [10:0] frame_len_i,
    input wire frame_tagged_i,
    input wire frame_cpu_tag_i,
    input wire [2:0] frame_dst_port_i,
    input wire frame_is_igmp_i,
    input wire [2:0] frame_src_port_i,
    input wire [11:0] frame_vid_i,
    input wire [11:0] port_vid_i,
    input wire [4:0] lookup_mask_i,
    input wire [4:0] preamble_mask_i,
    input wire [4:0] storm_en_i,
    input wire [4:0] bcast_block_i,
    input wire [4:0] port_is_10_i,
    input wire [4:0] sniff_src_hit_i,
    input wire [4:0] sniff_dst_hit_i,
    input wire high_pend_i,
    input wire low_pend_i,
    input wire tx_frame_start_i,
    input wire mii_congested_i,
    output reg frame_drop_o,
    output reg [4:0] dest_mask_o,
    output reg [11:0] vid_out_o,
    output reg [2:0] pretag_port_o,
    output reg pretag_valid_o,
    output reg [10:0] max_len_o,
    output reg [5:0] prio_reserve_o,
    output wire pick_high_o,
    output wire [4:0] sniff_hit_o,
    output wire [4:0] storm_over_o,
    output wire vlan_enable_o,
    output wire mii_half_duplex_o,
    output wire mii_10m_o,
    output wire mii_back_pressure_o,
    output wire mii_pause_o
);
    reg [2:0] policy_reg;
    reg [7:0] fwd_reg;
    reg [7:0] mii_reg;
    reg [7:0] storm_low_reg;
    reg strapped_reg;
    reg [25:0] tick100_reg;
    reg [28:0] tick10_reg;
    wire tick100;
    wire tick10;
    wire [10:0] budget;
    wire [10:0] limit;
    wire [4:0] dest;
    wire [11:0] vid;
    genvar gi;
    // last count of each storm period, cut to the counter widths
    localparam [25:0] CYC100_LAST = `STORM_CYC_100 - 1;
    localparam [28:0] CYC10_LAST = `STORM_CYC_10 - 1;

    // register writes; strap bits loaded one cycle after release
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            policy_reg <= 3'h0;
            fwd_reg <= `FO_RESET;
            mii_reg <= {5'h00, `MS_RATE_RESET};
            storm_low_reg <= `STORM_LOW_RESET;
            strapped_reg <= 1'b0;
        end else begin
            strapped_reg <= 1'b1;
            if (!strapped_reg) begin
                policy_reg[`FP_SIZE_CHECK_BIT] <= size_limit_strap_pin_i;
                mii_reg[`MS_HALF_BIT] <= duplex_strap_pin_i;
                mii_reg[`MS_FC_BIT] <= flow_ctrl_strap_pin_i;
                mii_reg[`MS_10BT_BIT] <= speed_strap_pin_i;
            end else if (reg_wr_i) begin
                case (reg_addr_i)
                    `ADDR_FRAME_POLICY: policy_reg <= reg_wdata_i[2:0];
                    `ADDR_FWD_OPTIONS: fwd_reg <= reg_wdata_i;
                    `ADDR_MII_STORM_HI: mii_reg <= reg_wdata_i;
                    `ADDR_STORM_LOW: storm_low_reg <= reg_wdata_i;
                    default: ;
                endcase
            end
        end
    end

    // register read; upper policy bits read their fixed defaults
    always @* begin
        case (reg_addr_i)
            `ADDR_FRAME_POLICY: reg_rdata_o = {`FP_RESET_UPPER, policy_reg};
            `ADDR_FWD_OPTIONS: reg_rdata_o = fwd_reg;
            `ADDR_MII_STORM_HI: reg_rdata_o = mii_reg;
            `ADDR_STORM_LOW: reg_rdata_o = storm_low_reg;
            default: reg_rdata_o = 8'h00;
        endcase
    end

    // length limit: huge overrides size check
    assign limit = policy_reg[`FP_HUGE_BIT] ? `LEN_HUGE :
        policy_reg[`FP_SIZE_CHECK_BIT] ? `LEN_NOCHECK :
        (frame_tagged_i && !(frame_cpu_tag_i && frame_dst_port_i != 3'd5)) ? `LEN_TAGGED : `LEN_UNTAGGED;

    // destination: direct preamble, tag mask or look-up, plus igmp
    assign dest = (fwd_reg[`FO_DIRECT_BIT] && frame_src_port_i == 3'd5) ? preamble_mask_i :
        fwd_reg[`FO_TAGMASK_BIT] ? frame_vid_i[4:0] :
        (frame_is_igmp_i && fwd_reg[`FO_IGMP_BIT]) ? 5'h10 : lookup_mask_i;

    // null vid replacement
    assign vid = (mii_reg[`MS_NULLVID_BIT] && frame_vid_i == 12'h000) ? port_vid_i : frame_vid_i;

    // registered frame decisions
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            frame_drop_o <= 1'b0;
            dest_mask_o <= 5'h00;
            vid_out_o <= 12'h000;
            pretag_port_o <= 3'h0;
            pretag_valid_o <= 1'b0;
            max_len_o <= `LEN_UNTAGGED;
            prio_reserve_o <= 6'h00;
        end else begin
            max_len_o <= limit;
            prio_reserve_o <= policy_reg[`FP_PRIO_RESERVE_BIT] ? `PRIO_RESERVE_BUFS : 6'h00;
            frame_drop_o <= frame_end_i && (frame_len_i > limit);
            if (frame_end_i) begin
                dest_mask_o <= dest;
                vid_out_o <= vid;
                pretag_port_o <= frame_src_port_i;
            end
            pretag_valid_o <= frame_end_i && fwd_reg[`FO_PRETAG_BIT] && dest[4];
        end
    end

    // period tick counters for 100 and 10 Mbit ports
    assign tick100 = (tick100_reg == CYC100_LAST);
    assign tick10 = (tick10_reg == CYC10_LAST);
    always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            tick100_reg <= 26'h0000000;
            tick10_reg <= 29'h00000000;
        end else begin
            tick100_reg <= tick100 ? 26'h0000000 : tick100_reg + 26'h0000001;
            tick10_reg <= tick10 ? 29'h00000000 : tick10_reg + 29'h00000001;
        end
    end

    assign budget = {mii_reg[`MS_RATE_HI:0], storm_low_reg};

    // one budget meter and sniff match per port
    generate
        for (gi = 0; gi < `NUM_PORTS; gi = gi + 1) begin : g_port
            storm_meter u_meter (
                .sys_clk_i(sys_clk_i),
                .rst_b_i(rst_b_i),
                .enable_i(storm_en_i[gi]),
                .period_tick_i(port_is_10_i[gi] ? tick10 : tick100),
                .block_i(bcast_block_i[gi]),
                .budget_i(budget),
                .over_o(storm_over_o[gi])
            );
            assign sniff_hit_o[gi] = fwd_reg[`FO_SNIFF_BIT] ? (sniff_src_hit_i[gi] && sniff_dst_hit_i[gi])
                : (sniff_src_hit_i[gi] || sniff_dst_hit_i[gi]);
        end
    endgenerate

    egress_scheduler u_sched (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .scheme_i(fwd_reg[`FO_SCHEME_HI:`FO_SCHEME_LO]),
        .high_pend_i(high_pend_i),
        .low_pend_i(low_pend_i),
        .frame_start_i(tx_frame_start_i),
        .pick_high_o(pick_high_o)
    );

    // mii mode controls
    assign vlan_enable_o = fwd_reg[`FO_VLAN_BIT];
    assign mii_half_duplex_o = mii_reg[`MS_HALF_BIT];
    assign mii_10m_o = mii_reg[`MS_10BT_BIT];
    assign mii_back_pressure_o = mii_reg[`MS_BP_BIT] && mii_reg[`MS_HALF_BIT] && mii_congested_i;
    assign mii_pause_o = mii_reg[`MS_FC_BIT] && !mii_reg[`MS_HALF_BIT] && mii_congested_i;
endmodule // switch_global_policy_control
`default_nettype wire

// [switch_global_policy_control_props.sv]
/*
 * checker for the global policy bank: register write-back, frame drop,
 * switch mii mode, sniff and storm gating relations at the top ports.
 * assumes one 50 MHz clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
`default_nettype none
`include "switch_policy_defines.vh"
module switch_global_policy_control_props (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic frame_end_i,
    input wire logic [10:0] frame_len_i,
    input wire logic frame_drop_o,
    input wire logic [5:0] prio_reserve_o,
    input wire logic [4:0] sniff_src_hit_i,
    input wire logic [4:0] sniff_dst_hit_i,
    input wire logic [4:0] sniff_hit_o,
    input wire logic [4:0] storm_en_i,
    input wire logic [4:0] storm_over_o,
    input wire logic vlan_enable_o,
    input wire logic mii_half_duplex_o,
    input wire logic mii_back_pressure_o,
    input wire logic mii_pause_o
);
    logic rdy;
    // writes count only after the strap load edge
    always_ff @(posedge sys_clk_i) begin
        rdy <= rst_b_i;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    a_fwd_write_back: assert property (rdy && reg_wr_i && reg_addr_i == `ADDR_FWD_OPTIONS |=>
        reg_addr_i != `ADDR_FWD_OPTIONS || reg_rdata_o == $past(reg_wdata_i)) else $error("write not read back");
    a_vlan_follows: assert property (rdy && reg_wr_i && reg_addr_i == `ADDR_FWD_OPTIONS |=>
        vlan_enable_o == $past(reg_wdata_i[7])) else $error("vlan enable wrong");
    a_drop_oversize: assert property (frame_end_i && frame_len_i > `LEN_HUGE |=> frame_drop_o)
        else $error("oversize frame kept");
    a_keep_short: assert property (frame_end_i && frame_len_i <= `LEN_UNTAGGED |=> !frame_drop_o)
        else $error("short frame dropped");
    a_reserve_set: assert property (rdy && reg_wr_i && reg_addr_i == `ADDR_FRAME_POLICY && reg_wdata_i[0]
        |-> ##[1:2] prio_reserve_o == `PRIO_RESERVE_BUFS) else $error("reserve not 48");
    a_pause_full: assert property (mii_half_duplex_o |-> !mii_pause_o) else $error("pause in half duplex");
    a_bp_half: assert property (!mii_half_duplex_o |-> !mii_back_pressure_o) else $error("bp in full duplex");
    a_sniff_bounds: assert property (((sniff_hit_o & ~(sniff_src_hit_i | sniff_dst_hit_i)) == 5'h00)
        && ((sniff_src_hit_i & sniff_dst_hit_i & ~sniff_hit_o) == 5'h00)) else $error("sniff match wrong");
    a_storm_gated: assert property ((storm_over_o & ~storm_en_i) == 5'h00) else $error("storm on idle port");
    a_unmapped_zero: assert property (reg_addr_i < 8'h04 || reg_addr_i > 8'h07 |-> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule // switch_global_policy_control_props
bind switch_global_policy_control switch_global_policy_control_props u_props (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .frame_end_i(frame_end_i),
    .frame_len_i(frame_len_i), .frame_drop_o(frame_drop_o), .prio_reserve_o(prio_reserve_o),
    .sniff_src_hit_i(sniff_src_hit_i), .sniff_dst_hit_i(sniff_dst_hit_i), .sniff_hit_o(sniff_hit_o),
    .storm_en_i(storm_en_i), .storm_over_o(storm_over_o), .vlan_enable_o(vlan_enable_o),
    .mii_half_duplex_o(mii_half_duplex_o), .mii_back_pressure_o(mii_back_pressure_o), .mii_pause_o(mii_pause_o));
`default_nettype wire

// [switch_global_policy_control_tb_top.sv]
/*
 * self-checking bench for the global policy bank: register access,
 * strap reset values, frame limits, forwarding, mii mode and storm.
 * assumes register writes are strobes and reads are combinational.
 */
`timescale 1ns/10ps
`default_nettype none
`include "switch_policy_defines.vh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module switch_global_policy_control_tb_top;
    logic sys_clk_i = 0, rst_b_i = 0, reg_wr_i = 0, fe = 0, ftag = 0, figmp = 0, cong = 1;
    logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o;
    logic [10:0] flen = 0;
    logic [11:0] fvid = 0, pvid = 0, vid_out;
    logic [2:0] fsrc = 0;
    logic [4:0] lmask = 0, sen = 0, blk = 0, shs = 0, shd = 0, dmask, sniff, over;
    logic [5:0] prio;
    logic drop, ptv, pick, half, m10, bp, pause, vlan;
    logic fcpu = 0, hpend = 1, lpend = 1, tstart = 0;
    logic [2:0] fdst = 1, src_sel = 2, pport;
    logic [4:0] pmask = 0, p10 = 0;
    logic [10:0] mlen;
    int fails = 0, n_compared = 0, cyc = 0, lim;
    int lens[8] = '{1518, 1519, 1522, 1523, 1536, 1537, 1916, 1917};
    switch_global_policy_control dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .size_limit_strap_pin_i(1'b1), .duplex_strap_pin_i(1'b1), .flow_ctrl_strap_pin_i(1'b0),
        .speed_strap_pin_i(1'b1), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .frame_end_i(fe), .frame_len_i(flen), .frame_tagged_i(ftag),
        .frame_cpu_tag_i(fcpu), .frame_dst_port_i(fdst), .frame_is_igmp_i(figmp), .frame_src_port_i(fsrc),
        .frame_vid_i(fvid), .port_vid_i(pvid), .lookup_mask_i(lmask), .preamble_mask_i(pmask),
        .storm_en_i(sen), .bcast_block_i(blk), .port_is_10_i(p10), .sniff_src_hit_i(shs),
        .sniff_dst_hit_i(shd), .high_pend_i(hpend), .low_pend_i(lpend), .tx_frame_start_i(tstart),
        .mii_congested_i(cong), .frame_drop_o(drop), .dest_mask_o(dmask), .vid_out_o(vid_out),
        .pretag_port_o(pport), .pretag_valid_o(ptv), .max_len_o(mlen), .prio_reserve_o(prio), .pick_high_o(pick),
        .sniff_hit_o(sniff), .storm_over_o(over), .vlan_enable_o(vlan), .mii_half_duplex_o(half),
        .mii_10m_o(m10), .mii_back_pressure_o(bp), .mii_pause_o(pause));
    // clock and hang guard
    initial begin
        forever #10 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // one register write, ends where unregistered outputs have settled
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        reg_addr_i <= a;
        @(negedge sys_clk_i);
        `CHK(reg_rdata_o, e)
    endtask
    // one frame descriptor, ends with the verdict visible
    task automatic frm(input int l, input logic t, input logic [11:0] v, input logic g, input logic [4:0] m);
        @(posedge sys_clk_i);
        {flen, ftag, fvid, figmp, lmask, fsrc, fe} <= {11'(l), t, v, g, m, src_sel, 1'b1};
        @(posedge sys_clk_i);
        fe <= 1'b0;
        @(negedge sys_clk_i);
    endtask
    task automatic blocks(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            blk <= 5'h03;
            @(posedge sys_clk_i);
            blk <= 5'h00;
        end
        @(negedge sys_clk_i);
    endtask
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rd_chk(8'h04, 8'hE2);
        rd_chk(8'h05, 8'h00);
        rd_chk(8'h06, 8'h50);
        rd_chk(8'h07, 8'h4A);
        rd_chk(8'h08, 8'h00);
        rd_chk(8'h03, 8'h00);
        `CHK({half, m10, pause}, 3'b110)
        for (int s = 3; s >= 0; s--) begin
            wr(8'h05, 8'(s << 2) | 8'h80);
            rd_chk(8'h05, 8'(s << 2) | 8'h80);
        end
        `CHK({pick, vlan}, 2'b11)
        // ratio 2: two high frames, then low gets its turn
        wr(8'h05, 8'h8C);
        repeat (2) begin
            @(posedge sys_clk_i);
            tstart <= 1'b1;
            @(posedge sys_clk_i);
            tstart <= 1'b0;
        end
        @(negedge sys_clk_i);
        `CHK(pick, 1'b0)
        for (int m = 0; m < 4; m++) begin
            wr(8'h04, 8'(m * 2));
            for (int i = 0; i < 16; i++) begin
                lim = (m >= 2) ? 1916 : (m == 1) ? 1536 : i[0] ? 1522 : 1518;
                frm(lens[i / 2], i[0], 12'h001, 1'b0, 5'h03);
                `CHK(drop, 1'(lens[i / 2] > lim))
                `CHK(mlen, 11'(lim))
            end
        end
        rd_chk(8'h04, 8'hE6);
        wr(8'h05, 8'h40);
        frm(64, 1'b0, 12'h001, 1'b1, 5'h03);
        `CHK(dmask, 5'h10)
        wr(8'h05, 8'h02);
        frm(64, 1'b1, 12'h3A5, 1'b0, 5'h03);
        `CHK(dmask, 5'h05)
        wr(8'h05, 8'h10);
        frm(64, 1'b0, 12'h001, 1'b0, 5'h10);
        `CHK(ptv, 1'b1)
        `CHK(pport, 3'd2)
        // direct mode from the mii port, then cpu tag exemption
        @(posedge sys_clk_i);
        {src_sel, pmask, fcpu, fdst} <= {3'd5, 5'h0A, 1'b1, 3'd1};
        wr(8'h05, 8'h20);
        frm(64, 1'b0, 12'h001, 1'b0, 5'h03);
        `CHK(dmask, 5'h0A)
        wr(8'h04, 8'h00);
        frm(1520, 1'b1, 12'h001, 1'b0, 5'h03);
        `CHK(drop, 1'b1)
        @(posedge sys_clk_i);
        fdst <= 3'd5;
        frm(1520, 1'b1, 12'h001, 1'b0, 5'h03);
        `CHK(drop, 1'b0)
        @(posedge sys_clk_i);
        {shs, shd, pvid} <= {5'h03, 5'h06, 12'h123};
        wr(8'h05, 8'h01);
        `CHK(sniff, 5'h02)
        wr(8'h05, 8'h00);
        `CHK(sniff, 5'h07)
        wr(8'h06, 8'h08);
        frm(64, 1'b1, 12'h000, 1'b0, 5'h03);
        `CHK(vid_out, 12'h123)
        frm(64, 1'b1, 12'h05A, 1'b0, 5'h03);
        `CHK(vid_out, 12'h05A)
        wr(8'h06, 8'hC0);
        `CHK({half, m10, bp, pause}, 4'b1010)
        wr(8'h06, 8'h30);
        `CHK({half, m10, bp, pause}, 4'b0101)
        wr(8'h06, 8'h40);
        `CHK({half, bp}, 2'b10)
        wr(8'h04, 8'h01);
        @(negedge sys_clk_i);
        `CHK(prio, 6'd48)
        wr(8'h04, 8'h00);
        @(negedge sys_clk_i);
        `CHK(prio, 6'd0)
        wr(8'h06, 8'h00);
        wr(8'h07, 8'h03);
        @(posedge sys_clk_i);
        sen <= 5'h01;
        blocks(2);
        `CHK(over, 5'h00)
        blocks(2);
        `CHK(over, 5'h01)
        wr(8'h06, 8'h01);
        `CHK(over, 5'h00)
        complete_run();
    end
endmodule // switch_global_policy_control_tb_top
`default_nettype wire

// [switch_policy_defines.vh]
/*
 * constants for the global policy bank: register indices, field
 * positions, reset values, frame limits and storm timing counts.
 * assumes a 50 MHz core clock.
 */
`ifndef SWITCH_POLICY_DEFINES_VH
`define SWITCH_POLICY_DEFINES_VH

// register indices on the management port
`define ADDR_FRAME_POLICY 8'h04
`define ADDR_FWD_OPTIONS 8'h05
`define ADDR_MII_STORM_HI 8'h06
`define ADDR_STORM_LOW 8'h07

// frame policy fields
`define FP_HUGE_BIT 2
`define FP_SIZE_CHECK_BIT 1
`define FP_PRIO_RESERVE_BIT 0
`define FP_RESET_UPPER 5'h1C

// forwarding option fields
`define FO_VLAN_BIT 7
`define FO_IGMP_BIT 6
`define FO_DIRECT_BIT 5
`define FO_PRETAG_BIT 4
`define FO_SCHEME_HI 3
`define FO_SCHEME_LO 2
`define FO_TAGMASK_BIT 1
`define FO_SNIFF_BIT 0
`define FO_RESET 8'h00

// switch mii and storm high fields
`define MS_BP_BIT 7
`define MS_HALF_BIT 6
`define MS_FC_BIT 5
`define MS_10BT_BIT 4
`define MS_NULLVID_BIT 3
`define MS_RATE_HI 2
`define MS_RATE_RESET 3'h0
`define STORM_LOW_RESET 8'h4A

// frame length limits in bytes
`define LEN_HUGE 11'd1916
`define LEN_NOCHECK 11'd1536
`define LEN_TAGGED 11'd1522
`define LEN_UNTAGGED 11'd1518

// buffers held back for high priority
`define PRIO_RESERVE_BUFS 6'd48

// storm periods
`define CLK_MHZ 50
`define STORM_PERIOD_100_MS 50
`define STORM_PERIOD_10_MS 500
`define STORM_CYC_100 (`STORM_PERIOD_100_MS * 1000 * `CLK_MHZ)
`define STORM_CYC_10 (`STORM_PERIOD_10_MS * 1000 * `CLK_MHZ)

// scheduling ratios (high frames per low frame)
`define RATIO_10 4'd10
`define RATIO_5 4'd5
`define RATIO_2 4'd2

`define NUM_PORTS 5
`endif
